// ### core/state_ptr_pkg.sv
package state_ptr_pkg;

   // ----------------------------------------------------------------
   // command header layout
   // ----------------------------------------------------------------
   localparam int HDR_TYPE_LSB = 29;
   localparam int HDR_SUBTYPE_LSB = 27;
   localparam int HDR_OPCODE_LSB = 24;
   localparam int HDR_SUBOP_LSB = 16;
   localparam int HDR_MBZ_LSB = 8;
   localparam logic [2:0] GRAPHICS_COMMAND_TYPE = 3'h3;
   localparam logic [1:0] RENDER_COMMAND_SUBTYPE = 2'h3;
   localparam logic [2:0] PIPELINED_OPCODE = 3'h0;
   localparam logic [7:0] STAGE_POINTER_SUBOP = 8'h00;
   localparam logic [7:0] BIND_LIST_POINTER_SUBOP = 8'h01;
   localparam logic [7:0] STAGE_POINTER_LEN = 8'h05;
   localparam logic [7:0] BIND_LIST_POINTER_LEN = 8'h04;

   // ----------------------------------------------------------------
   // dword positions and field positions
   // ----------------------------------------------------------------
   localparam logic [8:0] DW_1 = 9'h001;
   localparam logic [8:0] DW_2 = 9'h002;
   localparam logic [8:0] DW_3 = 9'h003;
   localparam logic [8:0] DW_4 = 9'h004;
   localparam logic [8:0] DW_5 = 9'h005;
   localparam logic [8:0] DW_6 = 9'h006;
   localparam int OFS32_LSB = 5;
   localparam int OFS64_LSB = 6;
   localparam int ENABLE_BIT = 0;

   // ----------------------------------------------------------------
   // register map (byte offsets) and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_STAGE_COUNT = 4'h8;
   localparam logic [3:0] REG_BIND_COUNT = 4'hC;
   localparam logic CONTROL_ACCEPT_RESET = 1'b1;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_UNKNOWN_BIT = 1;
   localparam int ST_MBZ_BIT = 2;
   localparam int ST_GEOM_ON_BIT = 3;
   localparam int ST_CLIP_ON_BIT = 4;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_STAGE = 4'b0010,
      ST_BIND = 4'b0100,
      ST_SKIP = 4'b1000
   } decode_state_e;

   typedef struct packed {
      logic [26:0] vertex_shader_descriptor;
      logic [26:0] geometry_stage_descriptor;
      logic geometry_stage_on;
      logic [26:0] clip_descriptor;
      logic clip_stage_on;
      logic [26:0] setup_stage_descriptor;
      logic [26:0] windower_descriptor;
      logic [25:0] colour_calc_descriptor;
   } stage_pointer_s;

   typedef struct packed {
      logic [26:0] geometry_bind;
      logic [26:0] clip_bind;
      logic [26:0] setup_bind;
      logic [26:0] pixel_bind;
   } bind_list_s;

endpackage

// ### core/pipeline_state_pointer_decoder.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// RQ1: geometry dword bit 0 picks geometry function or pass-through.
// RQ2: geometry offset ignored and not latched while geometry enable clear.
// RQ3: dword 3 bits 31:5 give 32-byte aligned clip offset.
// RQ4: dword 3 bit 0 picks clip function or pass-through.
// RQ5: issuer sends pipeline flush before turning clip off.
// RQ6: issuer keeps clip on when geometry may emit incomplete objects.
// RQ7: dword 4 bits 31:5 give setup offset.
// RQ8: dword 5 bits 31:5 give windower offset; bits 4:0 reserved.
// RQ9: dword 6 bits 31:6 give colour calc offset; bits 5:0 reserved.
// RQ10: bind list command is type 3, subtype 3, opcode 0, sub-op 01.
// RQ11: header bits 7:0 hold length minus two; decoder consumes that many.
// RQ12: bind dword 2 bits 31:5 give geometry bind table offset.
// RQ13: bind dword 3 bits 31:5 give clip bind table offset.
// RQ14: bind dword 4 bits 31:5 give setup bind table offset.
// RQ15: bind dword 5 bits 31:5 give pixel bind table offset.
// RQ16: issuer writes zeros into all reserved fields.
// RQ17: stage pointer command is type 3, subtype 3, opcode 0, sub-op 00.
// RQ18: stage dwords 1 and 2 bits 31:5 give vertex and geometry offsets.
// RQ19: all fields of a command are presented together after its last dword.
// RQ20: outputs hold until next command of same kind; cleared on reset.
module pipeline_state_pointer_decoder (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire logic [31:0] cmd_dword_in,
   output logic cmd_ready_out,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output state_ptr_pkg::stage_pointer_s stage_ptr_out,
   output logic stage_update_out,
   output state_ptr_pkg::bind_list_s bind_ptr_out,
   output logic bind_update_out
);
   import state_ptr_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   decode_state_e state_q, state_d;
   logic [8:0] idx_q;
   logic [7:0] len_q;
   stage_pointer_s stage_sh_q, stage_sh_d, stage_q;
   bind_list_s bind_sh_q, bind_sh_d, bind_q;
   logic stage_upd_q, bind_upd_q;
   logic accept_q, ready_q;
   logic unknown_q, mbz_q;
   logic [15:0] stage_cnt_q, bind_cnt_q;
   logic wait_q;
   logic [31:0] rdata_q;

   // ----------------------------------------------------------------
   // header decode
   // ----------------------------------------------------------------
   wire take = cmd_valid_in & ready_q;
   wire in_idle = (state_q == ST_IDLE);
   wire is_render_hdr =
      (cmd_dword_in[31:HDR_TYPE_LSB] == GRAPHICS_COMMAND_TYPE) &&
      (cmd_dword_in[28:HDR_SUBTYPE_LSB] == RENDER_COMMAND_SUBTYPE);
   wire is_pipe_hdr = is_render_hdr &&
      (cmd_dword_in[26:HDR_OPCODE_LSB] == PIPELINED_OPCODE);
   wire [7:0] hdr_subop = cmd_dword_in[23:HDR_SUBOP_LSB];
   wire is_stage_hdr = is_pipe_hdr &&
      (hdr_subop == STAGE_POINTER_SUBOP); // see RQ17
   wire is_bind_hdr = is_pipe_hdr &&
      (hdr_subop == BIND_LIST_POINTER_SUBOP); // see RQ10
   wire [7:0] hdr_len = cmd_dword_in[7:0];
   wire hdr_mbz_bad = |cmd_dword_in[15:HDR_MBZ_LSB];
   // last dword index is length field plus one, after the header
   wire last_dw = (idx_q == ({1'b0, len_q} + 9'h001)); // see RQ11
   wire body_take = take & ~in_idle;
   wire finishing = body_take & last_dw;
   wire geom_on_in = cmd_dword_in[ENABLE_BIT];
   wire is_stage = (state_q == ST_STAGE);
   wire is_bind = (state_q == ST_BIND);

   // ----------------------------------------------------------------
   // reserved-bit check on header and body dwords
   // ----------------------------------------------------------------
   // the issuer owns zeroing; the decoder only reports violations
   logic [5:0] mbz_mask;
   always_comb begin
      mbz_mask = 6'h00;
      if (is_stage) begin
         case (idx_q)
            DW_1, DW_4, DW_5: mbz_mask = 6'h1F;
            DW_2, DW_3: mbz_mask = 6'h1E;
            DW_6: mbz_mask = 6'h3F;
            default: mbz_mask = 6'h00;
         endcase
      end else if (is_bind) begin
         case (idx_q)
            DW_1, DW_2, DW_3, DW_4, DW_5: mbz_mask = 6'h1F;
            default: mbz_mask = 6'h00;
         endcase
      end
   end
   wire body_mbz_bad = |(cmd_dword_in[5:0] & mbz_mask); // see RQ16
   wire mbz_event = take & ((in_idle & (is_stage_hdr | is_bind_hdr) &
                    hdr_mbz_bad) | (~in_idle & body_mbz_bad));
   wire unknown_event = take & in_idle & ~is_stage_hdr & ~is_bind_hdr;

   // ----------------------------------------------------------------
   // shadow capture
   // ----------------------------------------------------------------
   always_comb begin
      stage_sh_d = stage_sh_q;
      if (take & is_stage) begin
         case (idx_q)
            DW_1: begin
               stage_sh_d.vertex_shader_descriptor =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ18
            end
            DW_2: begin
               stage_sh_d.geometry_stage_on = geom_on_in; // see RQ1
               // a disabled geometry stage keeps the offset it last held
               if (geom_on_in) begin
                  stage_sh_d.geometry_stage_descriptor =
                     cmd_dword_in[31:OFS32_LSB]; // see RQ2 RQ18
               end
            end
            DW_3: begin
               stage_sh_d.clip_descriptor =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ3
               stage_sh_d.clip_stage_on =
                  cmd_dword_in[ENABLE_BIT]; // see RQ4
            end
            DW_4: begin
               stage_sh_d.setup_stage_descriptor =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ7
            end
            DW_5: begin
               stage_sh_d.windower_descriptor =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ8
            end
            DW_6: begin
               stage_sh_d.colour_calc_descriptor =
                  cmd_dword_in[31:OFS64_LSB]; // see RQ9
            end
            default: begin
               stage_sh_d = stage_sh_q;
            end
         endcase
      end
   end

   always_comb begin
      bind_sh_d = bind_sh_q;
      if (take & is_bind) begin
         case (idx_q)
            DW_2: bind_sh_d.geometry_bind =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ12
            DW_3: bind_sh_d.clip_bind =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ13
            DW_4: bind_sh_d.setup_bind =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ14
            DW_5: bind_sh_d.pixel_bind =
                  cmd_dword_in[31:OFS32_LSB]; // see RQ15
            default: bind_sh_d = bind_sh_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (take & is_stage_hdr) begin
               state_d = ST_STAGE;
            end else if (take & is_bind_hdr) begin
               state_d = ST_BIND;
            end else if (take & is_render_hdr) begin
               // unknown render command: its own length tells what to drop
               state_d = ST_SKIP; // see RQ11
            end
         end
         ST_STAGE, ST_BIND, ST_SKIP: begin
            if (finishing) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_IDLE;
         idx_q <= 9'h000;
         len_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (take & in_idle) begin
            idx_q <= 9'h001;
            len_q <= hdr_len; // see RQ11
         end else if (body_take) begin
            idx_q <= idx_q + 9'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // shadow and presented state
   // ----------------------------------------------------------------
   // shadow keeps its own last values between commands so short commands keep old fields
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage_sh_q <= '0;
         bind_sh_q <= '0;
         stage_q <= '0; // see RQ20
         bind_q <= '0; // see RQ20
         stage_upd_q <= 1'b0;
         bind_upd_q <= 1'b0;
      end else begin
         stage_sh_q <= stage_sh_d;
         bind_sh_q <= bind_sh_d;
         stage_upd_q <= finishing & is_stage;
         bind_upd_q <= finishing & is_bind;
         if (finishing & is_stage) begin
            stage_q <= stage_sh_d; // see RQ19 RQ20
         end
         if (finishing & is_bind) begin
            bind_q <= bind_sh_d; // see RQ19 RQ20
         end
      end
   end

   // ----------------------------------------------------------------
   // status and counters
   // ----------------------------------------------------------------
   wire bus_go = (avs_read_in | avs_write_in) & ~wait_q;
   wire wr_go = avs_write_in & ~wait_q;
   wire wr_ctrl = wr_go & (avs_address_in == REG_CONTROL) &
                  avs_byteenable_in[0];
   wire wr_status = wr_go & (avs_address_in == REG_STATUS) &
                    avs_byteenable_in[0];
   wire clr_unknown = wr_status & avs_writedata_in[ST_UNKNOWN_BIT];
   wire clr_mbz = wr_status & avs_writedata_in[ST_MBZ_BIT];

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         accept_q <= CONTROL_ACCEPT_RESET;
         ready_q <= 1'b0;
         unknown_q <= 1'b0;
         mbz_q <= 1'b0;
         stage_cnt_q <= 16'h0000;
         bind_cnt_q <= 16'h0000;
      end else begin
         if (wr_ctrl) begin
            accept_q <= avs_writedata_in[0];
         end
         // ready is low out of reset and after an idle cycle with accept clear; a header taken in it stalls the next dword
         ready_q <= accept_q | ~in_idle;
         // a new event wins over a clear in the same cycle
         unknown_q <= unknown_event | (unknown_q & ~clr_unknown);
         mbz_q <= mbz_event | (mbz_q & ~clr_mbz);
         if (finishing & is_stage) begin
            stage_cnt_q <= stage_cnt_q + 16'h0001;
         end
         if (finishing & is_bind) begin
            bind_cnt_q <= bind_cnt_q + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // avalon slave
   // ----------------------------------------------------------------
   wire [31:0] status_word = {27'h0000000,
      stage_q.clip_stage_on, stage_q.geometry_stage_on,
      mbz_q, unknown_q, ~in_idle};
   logic [31:0] rmux;
   always_comb begin
      case (avs_address_in)
         REG_CONTROL: rmux = {31'h00000000, accept_q};
         REG_STATUS: rmux = status_word;
         REG_STAGE_COUNT: rmux = {16'h0000, stage_cnt_q};
         REG_BIND_COUNT: rmux = {16'h0000, bind_cnt_q};
         default: rmux = 32'h00000000;
      endcase
   end

   // one wait cycle per access: data is registered before release
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
         if (avs_read_in & wait_q) begin
            rdata_q <= rmux;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cmd_ready_out = ready_q;
   assign avs_readdata_out = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign stage_ptr_out = stage_q;
   assign stage_update_out = stage_upd_q;
   assign bind_ptr_out = bind_q;
   assign bind_update_out = bind_upd_q;

   wire unused_ok = bus_go;

endmodule

`default_nettype wire

// ### sim/state_ptr_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// decoder port checker
// ------------------------------------------
module state_ptr_checker (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire logic [31:0] cmd_dword_in,
   input wire logic cmd_ready_out,
   input wire state_ptr_pkg::stage_pointer_s stage_ptr_out,
   input wire logic stage_update_out,
   input wire state_ptr_pkg::bind_list_s bind_ptr_out,
   input wire logic bind_update_out
);
   import state_ptr_pkg::*;
   logic busy_q;
   logic [1:0] kind_q;
   logic [8:0] idx_q;
   logic [8:0] end_q;
   logic [31:0] clip_q;
   logic [31:0] col_q;
   logic [31:0] pix_q;
   wire take = cmd_valid_in && cmd_ready_out;
   wire rnd = cmd_dword_in[31:27] ==
      {GRAPHICS_COMMAND_TYPE, RENDER_COMMAND_SUBTYPE};
   wire pipe = rnd && cmd_dword_in[26:24] == PIPELINED_OPCODE;
   wire [1:0] kind_d = !pipe ? 2'h0 :
      cmd_dword_in[23:16] == STAGE_POINTER_SUBOP ? 2'h1 :
      cmd_dword_in[23:16] == BIND_LIST_POINTER_SUBOP ? 2'h2 : 2'h0;
   wire body = take && busy_q;
   wire st_last = body && kind_q == 2'h1 && idx_q == end_q;
   wire bd_last = body && kind_q == 2'h2 && idx_q == end_q;
   wire cap_clip = body && kind_q == 2'h1 && idx_q == DW_3;
   wire cap_col = body && kind_q == 2'h1 && idx_q == DW_6;
   wire cap_pix = body && kind_q == 2'h2 && idx_q == DW_5;
   // own dword index, so fields are tied to the dword that carried them
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_q <= 1'b0;
         kind_q <= 2'h0;
         idx_q <= 9'h000;
         end_q <= 9'h000;
      end else if (take) begin
         busy_q <= busy_q ? idx_q != end_q : rnd;
         kind_q <= busy_q ? kind_q : kind_d;
         idx_q <= busy_q ? idx_q + DW_1 : DW_1;
         end_q <= busy_q ? end_q : {1'b0, cmd_dword_in[7:0]} + DW_1;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clip_q <= 32'h0;
         col_q <= 32'h0;
         pix_q <= 32'h0;
      end else begin
         clip_q <= cap_clip ? cmd_dword_in : clip_q;
         col_q <= cap_col ? cmd_dword_in : col_q;
         pix_q <= cap_pix ? cmd_dword_in : pix_q;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_stage_end;
      ##1 stage_update_out ##1 !stage_update_out;
   endsequence
   sequence s_bind_end;
      ##1 bind_update_out ##1 !bind_update_out;
   endsequence
   AST_STAGE_DONE: assert property (st_last |-> s_stage_end)
      else $error("stage pulse missing");
   AST_STAGE_CAUSE: assert property (stage_update_out |-> $past(st_last))
      else $error("stage pulse without command");
   AST_BIND_DONE: assert property (bd_last |-> s_bind_end)
      else $error("bind pulse missing");
   AST_STAGE_HOLD: assert property (!stage_update_out |-> $stable(stage_ptr_out))
      else $error("stage fields moved");
   AST_BIND_HOLD: assert property (!bind_update_out |-> $stable(bind_ptr_out))
      else $error("bind fields moved");
   AST_GEOM_KEEP: assert property (stage_update_out &&
      !stage_ptr_out.geometry_stage_on |->
      $stable(stage_ptr_out.geometry_stage_descriptor))
      else $error("geometry offset taken while off");
   AST_CLIP_FIELDS: assert property (stage_update_out |->
      stage_ptr_out.clip_descriptor == clip_q[31:5] &&
      stage_ptr_out.clip_stage_on == clip_q[0])
      else $error("clip field wrong");
   AST_COLOUR: assert property (stage_update_out |->
      stage_ptr_out.colour_calc_descriptor == col_q[31:6])
      else $error("colour field wrong");
   AST_PIXEL_BIND: assert property (bind_update_out |->
      bind_ptr_out.pixel_bind == pix_q[31:5])
      else $error("pixel bind wrong");
   AST_READY_MID: assert property (busy_q |-> cmd_ready_out)
      else $error("ready dropped mid command");
endmodule
`default_nettype wire

// ### sim/cmd_streamer.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// command streamer model
// ------------------------------------------
module cmd_streamer (
   input wire logic clk_in,
   input wire logic ready_in,
   output logic valid_out,
   output logic [31:0] dword_out
);
   int gap = 0;
   initial begin
      valid_out = 1'b0;
      dword_out = 32'h0;
   end
   // gap > 0 gives a slow streamer that idles between dwords
   task automatic put(input logic [31:0] dw, output bit ok);
      repeat (gap) @(posedge clk_in);
      valid_out <= 1'b1;
      dword_out <= dw;
      ok = 1'b0;
      for (int i = 0; i < 50 && !ok; i++) begin
         @(posedge clk_in);
         ok = ready_in;
      end
      if (gap != 0) begin
         drop(dw);
      end
   endtask
   // released bus shows inverse data, never the stale dword
   task automatic drop(input logic [31:0] dw);
      valid_out <= 1'b0;
      dword_out <= ~dw;
   endtask
endmodule
`default_nettype wire

// ### sim/tb_pipeline_state_pointer_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// decoder bench
// ------------------------------------------
module tb_pipeline_state_pointer_decoder;
   import state_ptr_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic avs_rd = 1'b0;
   logic avs_wr = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, dword;
   logic valid, ready, waitreq, sup, bup;
   stage_pointer_s sp;
   bind_list_s bp;
   int errors = 0;
   int num_checks = 0;
   always #5 clk_in = ~clk_in;
   pipeline_state_pointer_decoder pipeline_state_pointer_decoder_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(valid),
      .cmd_dword_in(dword), .cmd_ready_out(ready),
      .avs_address_in(adr), .avs_read_in(avs_rd), .avs_write_in(avs_wr),
      .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdat), .avs_waitrequest_out(waitreq),
      .stage_ptr_out(sp), .stage_update_out(sup),
      .bind_ptr_out(bp), .bind_update_out(bup));
   cmd_streamer cmd_streamer_i (.clk_in(clk_in), .ready_in(ready),
      .valid_out(valid), .dword_out(dword));
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [191:0] s,
                      input logic [191:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic avs(input bit wr, input logic [3:0] ad,
                      input logic [31:0] wd, output logic [31:0] rd);
      int i;
      @(posedge clk_in);
      avs_rd <= !wr;
      avs_wr <= wr;
      adr <= ad;
      wdat <= wd;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_in);
         if (waitreq === 1'b0) break;
      end
      rd = rdat;
      avs_rd <= 1'b0;
      avs_wr <= 1'b0;
      if (i == 20) begin
         errors++;
         end_of_test();
      end
   endtask
   task automatic rd_chk(input string n, input logic [3:0] ad,
                         input logic [31:0] e);
      logic [31:0] d;
      avs(1'b0, ad, 32'h0, d);
      chk(n, 192'(d), 192'(e));
   endtask
   task automatic send(input logic [31:0] q[$]);
      bit ok;
      foreach (q[i]) begin
         cmd_streamer_i.put(q[i], ok);
         if (!ok) begin
            errors++;
            end_of_test();
         end
      end
      if (cmd_streamer_i.gap == 0) begin
         cmd_streamer_i.drop(q[q.size()-1]);
      end
   endtask
   // pulse lasts one cycle, so it is looked for cycle by cycle
   task automatic wait_upd(input bit bnd);
      for (int i = 0; i < 8; i++) begin
         #1;
         if ((bnd ? bup : sup) === 1'b1) return;
         @(posedge clk_in);
      end
      errors++;
      end_of_test();
   endtask
   task automatic chk_stage(input logic [31:0] e[1:6]);
      stage_pointer_s x;
      x = '{e[1][31:5], e[2][31:5], e[2][0], e[3][31:5], e[3][0],
            e[4][31:5], e[5][31:5], e[6][31:6]};
      chk("stage", 192'(sp), 192'(x));
   endtask
   initial begin
      logic [31:0] a[1:6], b[1:6], eb[1:6], d;
      logic [31:0] q[$];
      bind_list_s x;
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      chk("stage_rst", 192'(sp), 192'h0);
      chk("bind_rst", 192'(bp), 192'h0);
      rd_chk("control", REG_CONTROL, 32'h1);
      rd_chk("unmapped", 4'h2, 32'h0);
      // accept off must stall the stream at a header boundary
      avs(1'b1, REG_CONTROL, 32'h0, d);
      rd_chk("control_off", REG_CONTROL, 32'h0);
      chk("ready_off", 192'(ready), 192'h0);
      avs(1'b1, REG_CONTROL, 32'h1, d);
      rd_chk("control_on", REG_CONTROL, 32'h1);
      chk("ready_on", 192'(ready), 192'h1);
      // geometry on with clip on, reserved bits zero
      a = '{32'h1234_5660, 32'h2000_0041, 32'h3000_0081, 32'h4000_00A0,
            32'h5000_00C0, 32'h6000_0040};
      send('{32'h7800_0005, a[1], a[2], a[3], a[4], a[5], a[6]});
      wait_upd(1'b0);
      chk_stage(a);
      cmd_streamer_i.gap = 2;
      send('{32'h0200_0000});
      b = '{32'h1357_9BE0, 32'h7700_0020, 32'h3300_0020, 32'h4400_0000,
            32'h5500_0000, 32'h6600_0055};
      send('{32'h7800_0005, b[1], b[2], b[3], b[4], b[5], b[6]});
      wait_upd(1'b0);
      eb = b;
      eb[2] = {a[2][31:5], b[2][4:0]};
      chk_stage(eb);
      rd_chk("status", REG_STATUS, 32'h0000_0006);
      avs(1'b1, REG_STATUS, 32'h0000_0006, d);
      rd_chk("status_clr", REG_STATUS, 32'h0);
      cmd_streamer_i.gap = 0;
      // unknown sub-op: a stage header inside its body must be skipped
      send('{32'h7802_0001, 32'h7800_0005, 32'h0});
      for (int n = 4; n < 6; n++) begin
         d = 32'h0100_0000 * n;
         q = '{32'h7801_0000 | 32'(n), 32'h0, d + 32'hA000_0020,
               d + 32'hB000_0040, d + 32'hC000_0060, d + 32'hD000_0080};
         if (n == 5) begin
            q.push_back(32'h7800_0005);
         end
         send(q);
         wait_upd(1'b1);
         x = '{q[2][31:5], q[3][31:5], q[4][31:5], q[5][31:5]};
         chk("bind", 192'(bp), 192'(x));
      end
      chk_stage(eb);
      rd_chk("stage_cnt", REG_STAGE_COUNT, 32'h2);
      rd_chk("bind_cnt", REG_BIND_COUNT, 32'h2);
      end_of_test();
   end
endmodule
bind pipeline_state_pointer_decoder state_ptr_checker state_ptr_checker_i (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
   .cmd_dword_in(cmd_dword_in), .cmd_ready_out(cmd_ready_out),
   .stage_ptr_out(stage_ptr_out), .stage_update_out(stage_update_out),
   .bind_ptr_out(bind_ptr_out), .bind_update_out(bind_update_out));
`default_nettype wire
